// ### tfp_pkg.sv
package tfp_pkg;

  // ----------------------------------------------------------------
  // Address space and trace memory geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 15;
  localparam int          FLAG_DEPTH   = 32768;
  localparam int          PTR_W        = 13;
  localparam logic [14:0] ADDR_MAX     = 15'h7FFF;
  localparam logic [14:0] LIMIT_SMALL  = 15'h07DF;
  localparam logic [14:0] LIMIT_LARGE  = 15'h0FDF;
  localparam logic [14:0] LIMIT_EXPAND = 15'h7FFF;
  localparam logic [14:0] ADDR_ZERO    = 15'h0000;
  localparam logic [12:0] PTR_ZERO     = 13'h0000;
  localparam logic [12:0] PTR_ONE      = 13'h0001;
  localparam logic [12:0] PTR_LAST     = 13'h1FFF;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_WRITE_FLAGS    = 5'b0_0001,
    OP_READ_FLAGS     = 5'b0_0010,
    OP_CLEAR_PTR      = 5'b0_0100,
    OP_SET_QUALIFIER  = 5'b0_1000,
    OP_SELECT_REGS    = 5'b1_0000
  } tfp_op_e;

  typedef enum logic [2:0] {
    QUAL_FREE_RUN     = 3'b001,
    QUAL_ENABLE_FLAG  = 3'b010,
    QUAL_DISABLED     = 3'b100
  } tfp_qual_e;

  typedef enum logic [2:0] {
    MODE_SMALL        = 3'b001,
    MODE_LARGE        = 3'b010,
    MODE_EXPAND       = 3'b100
  } tfp_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE           = 3'b001,
    ST_WRITE          = 3'b010,
    ST_READ           = 3'b100
  } tfp_state_e;

  localparam tfp_qual_e QUAL_RESET = QUAL_FREE_RUN;

  // ----------------------------------------------------------------
  // Host command carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    tfp_op_e          op;
    logic             whole;     // Whole-array form
    logic             has_data;  // A value was supplied
    logic             value;     // Flag value to write
    logic [14:0]      addr_lo;
    logic [14:0]      addr_hi;
    tfp_qual_e        qual;
  } tfp_cmd_s;

endpackage

// ### tfp_flag_ram.sv
`timescale 1ns/10ps
module tfp_flag_ram
  import tfp_pkg::*;
(
  // Clock
  input  wire logic              clk,
  input  wire logic              ce,
  // Execution lookup port
  input  wire logic [ADDR_W-1:0] ex_addr,
  output logic                   ex_q,
  // Host port
  input  wire logic [ADDR_W-1:0] h_addr,
  input  wire logic              h_we,
  input  wire logic              h_d,
  output logic                   h_q
);

  // One bit per code address; contents are undefined until cleared
  logic mem [FLAG_DEPTH];

  // ----------------------------------------------------------------
  // Lookup port, registered read
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (ce) begin
      ex_q <= mem[ex_addr];
    end
  end

  // ----------------------------------------------------------------
  // Host port, write or registered read
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (ce) begin
      if (h_we) begin
        mem[h_addr] <= h_d;
      end
      h_q <= mem[h_addr];
    end
  end

endmodule // tfp_flag_ram

// ### tfp_trace_filter.sv
`timescale 1ns/10ps
module tfp_trace_filter
  import tfp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              MCLK,
  input  wire logic              RST,
  input  wire logic              CE,
  // Configuration
  input  wire tfp_mode_e         OP_MODE,
  // Host commands
  input  wire logic              CMD_VALID,
  input  wire tfp_cmd_s          CMD,
  output logic                   CMD_READY,
  // Flag read answers
  output logic                   RD_VALID,
  output logic [ADDR_W-1:0]      RD_ADDR,
  output logic                   RD_BIT,
  // Execution stream
  input  wire logic              EXEC_VALID,
  input  wire logic              EXEC_FIRST,
  input  wire logic [ADDR_W-1:0] EXEC_ADDR,
  input  wire logic              GO_WITH_START,
  // Trace memory write
  output logic                   TRACE_WE,
  output logic [PTR_W-1:0]       TRACE_ADDR,
  // Pointer status
  output logic [PTR_W-1:0]       PTR_VALUE,
  output logic                   PTR_OVF,
  output tfp_qual_e              QUAL_MODE
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  tfp_state_e        state_ff;
  tfp_state_e        nxt_state;
  tfp_qual_e         qual_ff;
  logic [ADDR_W-1:0] walk_addr_ff;
  logic [ADDR_W-1:0] walk_hi_ff;
  logic              wr_val_ff;
  logic [ADDR_W-1:0] limit;
  logic [ADDR_W-1:0] cmd_hi;
  logic              cmd_take;
  logic              cmd_ok;
  logic              ex_v_ff;
  logic              flag_q;
  logic              host_q;
  logic              hit;
  logic [PTR_W-1:0]  ptr_ff;
  logic              ovf_ff;
  logic              ptr_clear;
  logic              host_clear;
  logic              trace_we_ff;
  logic [PTR_W-1:0]  trace_addr_ff;
  logic              rd_valid_ff;
  logic [ADDR_W-1:0] rd_addr_ff;

  // ----------------------------------------------------------------
  // Flag array
  // ----------------------------------------------------------------
  // One storage bit per code address, lookup and host ports apart
  tfp_flag_ram u_flags (
    .clk     (MCLK),
    .ce      (CE),
    .ex_addr (EXEC_ADDR),
    .ex_q    (flag_q),
    .h_addr  (walk_addr_ff),
    .h_we    (state_ff == ST_WRITE),
    .h_d     (wr_val_ff),
    .h_q     (host_q)
  );

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Upper address bound of the current operating mode
  always_comb begin
    case (OP_MODE)
      MODE_SMALL:  limit = LIMIT_SMALL;
      MODE_LARGE:  limit = LIMIT_LARGE;
      MODE_EXPAND: limit = LIMIT_EXPAND;
      default:     limit = LIMIT_SMALL;
    endcase
  end

  // Whole-array writes span the entire space; a range is clipped to the mode
  always_comb begin
    if (CMD.whole) begin
      cmd_hi = (CMD.op == OP_WRITE_FLAGS) ? ADDR_MAX : limit;
    end else if (CMD.addr_hi > limit) begin
      cmd_hi = limit;
    end else begin
      cmd_hi = CMD.addr_hi;
    end
  end

  // One command at a time keeps writes in issue order
  assign CMD_READY = (state_ff == ST_IDLE);
  assign cmd_take  = CMD_VALID && CMD_READY && CE;
  // A range starting past its end or past the mode limit does nothing
  assign cmd_ok    = CMD.whole || ((CMD.addr_lo <= cmd_hi) && (CMD.addr_lo <= limit));

  // ----------------------------------------------------------------
  // Host walk state machine
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (cmd_take && cmd_ok && CMD.op == OP_WRITE_FLAGS) begin
          nxt_state = ST_WRITE;
        end else if (cmd_take && cmd_ok && CMD.op == OP_READ_FLAGS) begin
          nxt_state = ST_READ;
        end
      end
      ST_WRITE, ST_READ: begin
        if (walk_addr_ff == walk_hi_ff) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge MCLK) begin
    if (RST) begin
      state_ff <= ST_IDLE;
    end else if (CE) begin
      state_ff <= nxt_state;
    end
  end

  // Walk address: loaded from the command, then one address per cycle
  always_ff @(posedge MCLK) begin
    if (RST) begin
      walk_addr_ff <= ADDR_ZERO;
      walk_hi_ff   <= ADDR_ZERO;
      wr_val_ff    <= 1'b0;
    end else if (CE) begin
      if (state_ff == ST_IDLE && cmd_take) begin
        walk_addr_ff <= CMD.whole ? ADDR_ZERO : CMD.addr_lo;
        walk_hi_ff   <= cmd_hi;
        wr_val_ff    <= CMD.has_data ? CMD.value : 1'b0;
      end else if (state_ff != ST_IDLE && walk_addr_ff != walk_hi_ff) begin
        walk_addr_ff <= walk_addr_ff + PTR_ONE[0 +: 1];
      end
    end
  end

  // Read answers line up with the registered memory output
  always_ff @(posedge MCLK) begin
    if (RST) begin
      rd_valid_ff <= 1'b0;
      rd_addr_ff  <= ADDR_ZERO;
    end else if (CE) begin
      rd_valid_ff <= (state_ff == ST_READ);
      rd_addr_ff  <= walk_addr_ff;
    end
  end

  assign RD_VALID = rd_valid_ff;
  assign RD_ADDR  = rd_addr_ff;
  assign RD_BIT   = host_q;

  // ----------------------------------------------------------------
  // Trace qualifier setting
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (RST) begin
      qual_ff <= QUAL_RESET;
    end else if (cmd_take && CMD.op == OP_SET_QUALIFIER) begin
      qual_ff <= CMD.qual;
    end
  end

  assign QUAL_MODE = qual_ff;

  // ----------------------------------------------------------------
  // Execution qualification
  // ----------------------------------------------------------------
  // Later bytes of a multi-byte instruction never reach the decision
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ex_v_ff <= 1'b0;
    end else if (CE) begin
      ex_v_ff <= EXEC_VALID && EXEC_FIRST;
    end
  end

  // Flag arrives one cycle after the address, together with ex_v_ff
  always_comb begin
    case (qual_ff)
      QUAL_FREE_RUN:    hit = ex_v_ff;
      QUAL_ENABLE_FLAG: hit = ex_v_ff && flag_q;
      QUAL_DISABLED:    hit = 1'b0;
      default:          hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Trace pointer and overflow
  // ----------------------------------------------------------------
  assign host_clear = cmd_take && CMD.op == OP_CLEAR_PTR;
  assign ptr_clear  = host_clear || GO_WITH_START ||
                      (cmd_take && CMD.op == OP_SELECT_REGS);

  // Clear wins over a same-cycle advance so the host sees exactly 0
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ptr_ff <= PTR_ZERO;
    end else if (CE) begin
      if (ptr_clear) begin
        ptr_ff <= PTR_ZERO;
      end else if (hit) begin
        ptr_ff <= ptr_ff + PTR_ONE;
      end
    end
  end

  // A wrap in the clearing cycle still sets the flag: no lost overflow
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ovf_ff <= 1'b0;
    end else if (CE) begin
      if (hit && ptr_ff == PTR_LAST) begin
        ovf_ff <= 1'b1;
      end else if (host_clear) begin
        ovf_ff <= 1'b0;
      end
    end
  end

  // Record strobe carries the slot that the pointer held before advancing
  always_ff @(posedge MCLK) begin
    if (RST) begin
      trace_we_ff   <= 1'b0;
      trace_addr_ff <= PTR_ZERO;
    end else if (CE) begin
      trace_we_ff   <= hit;
      trace_addr_ff <= ptr_ff;
    end
  end

  assign TRACE_WE   = trace_we_ff;
  assign TRACE_ADDR = trace_addr_ff;
  assign PTR_VALUE  = ptr_ff;
  assign PTR_OVF    = ovf_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_first_byte;
    CE && EXEC_VALID && EXEC_FIRST;
  endsequence

  sequence s_later_byte;
    CE && EXEC_VALID && !EXEC_FIRST;
  endsequence

  a_free_run_all: assert property (@(posedge MCLK) disable iff (RST)
    s_first_byte ##1 (CE && qual_ff == QUAL_FREE_RUN) |=> TRACE_WE)
    else $error("free-run instruction not recorded");

  a_flag_gates_rec: assert property (@(posedge MCLK) disable iff (RST)
    s_first_byte ##1 (CE && qual_ff == QUAL_ENABLE_FLAG) |=> TRACE_WE == $past(flag_q))
    else $error("record does not follow enable flag");

  a_later_byte_skip: assert property (@(posedge MCLK) disable iff (RST)
    s_later_byte ##1 CE |=> !TRACE_WE)
    else $error("later instruction byte was recorded");

  a_ptr_clear_zero: assert property (@(posedge MCLK) disable iff (RST)
    CE && ptr_clear |=> PTR_VALUE == PTR_ZERO)
    else $error("pointer not zero after clear");

  a_ptr_advance: assert property (@(posedge MCLK) disable iff (RST)
    CE && hit && !ptr_clear |=> PTR_VALUE == $past(ptr_ff) + PTR_ONE && TRACE_WE)
    else $error("pointer did not advance on record");

  a_ovf_on_wrap: assert property (@(posedge MCLK) disable iff (RST)
    CE && hit && ptr_ff == PTR_LAST |=> PTR_OVF && PTR_VALUE == PTR_ZERO)
    else $error("overflow missing after wrap");

  a_ovf_host_clear: assert property (@(posedge MCLK) disable iff (RST)
    CE && host_clear && !(hit && ptr_ff == PTR_LAST) |=> !PTR_OVF)
    else $error("overflow survived host clear");

  a_qual_reset_val: assert property (@(posedge MCLK)
    RST |=> QUAL_MODE == QUAL_FREE_RUN)
    else $error("reset did not select free-run");

  a_clear_all_load: assert property (@(posedge MCLK) disable iff (RST)
    cmd_take && CMD.op == OP_WRITE_FLAGS && CMD.whole && !CMD.has_data
    |=> state_ff == ST_WRITE && !wr_val_ff && walk_hi_ff == ADDR_MAX && walk_addr_ff == ADDR_ZERO)
    else $error("whole clear not started correctly");

  a_read_answer: assert property (@(posedge MCLK) disable iff (RST)
    CE && state_ff == ST_READ |=> RD_VALID && RD_ADDR == $past(walk_addr_ff))
    else $error("flag read answer missing");

  a_walk_limit: assert property (@(posedge MCLK) disable iff (RST)
    state_ff == ST_READ |-> walk_hi_ff <= limit && walk_addr_ff <= walk_hi_ff)
    else $error("read walk outside range");

endmodule // tfp_trace_filter

// ### tfp_host_model.sv
`timescale 1ns/10ps
module tfp_host_model
  import tfp_pkg::*;
(
  // Clock and enable
  input  wire logic MCLK,
  input  wire logic CE,
  // Command handshake
  input  wire logic CMD_READY,
  output logic      CMD_VALID,
  output tfp_cmd_s  CMD
);
  // ----------------------------------------------------------------
  // Idle at time zero
  // ----------------------------------------------------------------
  initial begin
    CMD_VALID = 1'b0;
    CMD       = '0;
  end

  // ----------------------------------------------------------------
  // One command: optional stall, hold until taken, wait out the walk
  // ----------------------------------------------------------------
  // Bounded waits so a stuck handshake reports instead of hanging
  task automatic send(input tfp_cmd_s c, input int gap, output bit ok);
    int n;
    ok = 1'b0;
    repeat (gap) @(posedge MCLK);
    @(posedge MCLK);
    CMD_VALID <= 1'b1;
    CMD       <= c;
    for (n = 0; n < 64; n++) begin
      @(posedge MCLK);
      if (CMD_READY && CE) break;
    end
    if (n == 64) return;
    CMD_VALID <= 1'b0;
    #1;
    n = 0;
    while (!CMD_READY && n < 40000) begin
      @(posedge MCLK);
      #1;
      n++;
    end
    ok = (CMD_READY === 1'b1);
  endtask
endmodule // tfp_host_model

// ### tfp_trace_filter_test.sv
`timescale 1ns/10ps
module tfp_trace_filter_test
  import tfp_pkg::*;
;
  typedef struct packed {
    logic [14:0] addr;
    logic        first;
    logic        we;
  } tfp_row_s;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              MCLK, RST, CE, EXEC_VALID, EXEC_FIRST, GO_WITH_START;
  logic              CMD_VALID, CMD_READY, RD_VALID, RD_BIT, TRACE_WE, PTR_OVF;
  tfp_mode_e         OP_MODE;
  tfp_qual_e         QUAL_MODE;
  tfp_cmd_s          CMD;
  logic [ADDR_W-1:0] EXEC_ADDR, RD_ADDR;
  logic [PTR_W-1:0]  TRACE_ADDR, PTR_VALUE, exp_ptr;
  logic [15:0]       rd_bit;
  int                rd_cnt, n_fail, compares, i;
  bit                ok;
  tfp_row_s          rows [5];

  tfp_trace_filter i_tfp_trace_filter (.MCLK(MCLK), .RST(RST), .CE(CE), .OP_MODE(OP_MODE),
    .CMD_VALID(CMD_VALID), .CMD(CMD), .CMD_READY(CMD_READY), .RD_VALID(RD_VALID),
    .RD_ADDR(RD_ADDR), .RD_BIT(RD_BIT), .EXEC_VALID(EXEC_VALID), .EXEC_FIRST(EXEC_FIRST),
    .EXEC_ADDR(EXEC_ADDR), .GO_WITH_START(GO_WITH_START), .TRACE_WE(TRACE_WE),
    .TRACE_ADDR(TRACE_ADDR), .PTR_VALUE(PTR_VALUE), .PTR_OVF(PTR_OVF), .QUAL_MODE(QUAL_MODE));

  tfp_host_model i_tfp_host_model (.MCLK(MCLK), .CE(CE), .CMD_READY(CMD_READY),
    .CMD_VALID(CMD_VALID), .CMD(CMD));

  // Clock, 8 ns
  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end

  // Collect read answers by low address nibble
  always @(posedge MCLK) begin
    if (RD_VALID === 1'b1) begin
      rd_cnt <= rd_cnt + 1;
      rd_bit[RD_ADDR[3:0]] <= RD_BIT;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t bit got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic chkp(input logic [PTR_W-1:0] got, input logic [PTR_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t count got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic tfp_cmd_s mk(input tfp_op_e op, input logic wh, input logic hd,
    input logic v, input logic [14:0] lo, input logic [14:0] hi, input tfp_qual_e q);
    mk = '{op, wh, hd, v, lo, hi, q};
  endfunction

  task automatic host(input tfp_cmd_s c, input int gap);
    i_tfp_host_model.send(c, gap, ok);
    chk1(ok, 1'b1);
    if (!ok) stop_test();
  endtask

  // Record stands in the cycle after the edge that follows the taking edge
  task automatic exec(input logic [14:0] a, input logic f, input logic we);
    @(posedge MCLK);
    EXEC_VALID <= 1'b1;
    EXEC_FIRST <= f;
    EXEC_ADDR  <= a;
    @(posedge MCLK);
    EXEC_VALID <= 1'b0;
    @(posedge MCLK);
    #1;
    chk1(TRACE_WE, we);
    if (we) begin
      chkp(TRACE_ADDR, exp_ptr);
      exp_ptr++;
    end
    chkp(PTR_VALUE, exp_ptr);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    RST           = 1'b1;
    CE            = 1'b1;
    OP_MODE       = MODE_EXPAND;
    EXEC_VALID    = 1'b0;
    EXEC_FIRST    = 1'b0;
    EXEC_ADDR     = '0;
    GO_WITH_START = 1'b0;
    n_fail        = 0;
    compares      = 0;
    rd_cnt        = 0;
    exp_ptr       = PTR_ZERO;
    // Flags 2 and 4 set; later bytes never qualify
    rows = '{'{15'h0002, 1'b1, 1'b1}, '{15'h0003, 1'b1, 1'b0}, '{15'h0004, 1'b0, 1'b0},
             '{15'h0004, 1'b1, 1'b1}, '{15'h0001, 1'b1, 1'b0}};
    repeat (16) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    #1;
    chkp(PTR_VALUE, PTR_ZERO);
    chk1(PTR_OVF, 1'b0);
    chk1(QUAL_MODE === QUAL_FREE_RUN, 1'b1);
    // Whole clear with a stray value bit, then range, then override
    host(mk(OP_WRITE_FLAGS, 1'b1, 1'b0, 1'b1, ADDR_ZERO, ADDR_ZERO, QUAL_FREE_RUN), 0);
    host(mk(OP_WRITE_FLAGS, 1'b0, 1'b1, 1'b1, 15'h0002, 15'h0004, QUAL_FREE_RUN), 0);
    host(mk(OP_WRITE_FLAGS, 1'b0, 1'b1, 1'b0, 15'h0003, 15'h0003, QUAL_FREE_RUN), 2);
    host(mk(OP_READ_FLAGS, 1'b0, 1'b0, 1'b0, 15'h0001, 15'h0005, QUAL_FREE_RUN), 0);
    host(mk(OP_READ_FLAGS, 1'b0, 1'b0, 1'b0, 15'h0003, 15'h0005, QUAL_FREE_RUN), 0);
    repeat (2) @(posedge MCLK);
    chkp(13'(rd_cnt), 13'h0008);
    for (i = 1; i < 6; i++) chk1(rd_bit[i], i == 2 || i == 4);
    // Small mode clips the read at its limit; a whole read stops there too
    @(posedge MCLK);
    OP_MODE <= MODE_SMALL;
    host(mk(OP_READ_FLAGS, 1'b0, 1'b0, 1'b0, 15'h07DD, 15'h07E5, QUAL_FREE_RUN), 0);
    repeat (2) @(posedge MCLK);
    chkp(13'(rd_cnt), 13'h000B);
    host(mk(OP_READ_FLAGS, 1'b1, 1'b0, 1'b0, ADDR_ZERO, ADDR_ZERO, QUAL_FREE_RUN), 0);
    repeat (2) @(posedge MCLK);
    chkp(13'(rd_cnt), 13'h07EB);
    // Large mode clips at its own limit; a range past it returns nothing
    @(posedge MCLK);
    OP_MODE <= MODE_LARGE;
    host(mk(OP_READ_FLAGS, 1'b0, 1'b0, 1'b0, 15'h0FDE, 15'h0FE2, QUAL_FREE_RUN), 0);
    host(mk(OP_READ_FLAGS, 1'b0, 1'b0, 1'b0, 15'h0FE0, 15'h0FE2, QUAL_FREE_RUN), 0);
    repeat (2) @(posedge MCLK);
    chkp(13'(rd_cnt), 13'h07ED);
    @(posedge MCLK);
    OP_MODE <= MODE_EXPAND;
    exec(15'h0003, 1'b1, 1'b1);
    host(mk(OP_SET_QUALIFIER, 1'b0, 1'b0, 1'b0, ADDR_ZERO, ADDR_ZERO, QUAL_ENABLE_FLAG), 0);
    for (i = 0; i < 5; i++) exec(rows[i].addr, rows[i].first, rows[i].we);
    // Each pointer-zeroing cause
    host(mk(OP_CLEAR_PTR, 1'b0, 1'b0, 1'b0, ADDR_ZERO, ADDR_ZERO, QUAL_FREE_RUN), 0);
    exp_ptr = PTR_ZERO;
    chkp(PTR_VALUE, exp_ptr);
    exec(15'h0002, 1'b1, 1'b1);
    @(posedge MCLK);
    GO_WITH_START <= 1'b1;
    @(posedge MCLK);
    GO_WITH_START <= 1'b0;
    #1;
    exp_ptr = PTR_ZERO;
    chkp(PTR_VALUE, exp_ptr);
    exec(15'h0002, 1'b1, 1'b1);
    host(mk(OP_SELECT_REGS, 1'b0, 1'b0, 1'b0, ADDR_ZERO, ADDR_ZERO, QUAL_FREE_RUN), 0);
    exp_ptr = PTR_ZERO;
    chkp(PTR_VALUE, exp_ptr);
    // Full wrap of the pointer, back to back records
    host(mk(OP_SET_QUALIFIER, 1'b0, 1'b0, 1'b0, ADDR_ZERO, ADDR_ZERO, QUAL_FREE_RUN), 0);
    @(posedge MCLK);
    EXEC_VALID <= 1'b1;
    EXEC_FIRST <= 1'b1;
    EXEC_ADDR  <= 15'h0005;
    repeat (8192) @(posedge MCLK);
    EXEC_VALID <= 1'b0;
    #1;
    chkp(PTR_VALUE, 13'h1FFF);
    chk1(PTR_OVF, 1'b0);
    repeat (2) @(posedge MCLK);
    #1;
    chkp(PTR_VALUE, PTR_ZERO);
    chk1(PTR_OVF, 1'b1);
    host(mk(OP_CLEAR_PTR, 1'b0, 1'b0, 1'b0, ADDR_ZERO, ADDR_ZERO, QUAL_FREE_RUN), 0);
    chk1(PTR_OVF, 1'b0);
    chkp(PTR_VALUE, PTR_ZERO);
    // Clock enable low: a presented instruction is neither taken nor recorded
    @(posedge MCLK);
    CE         <= 1'b0;
    EXEC_VALID <= 1'b1;
    repeat (3) @(posedge MCLK);
    CE         <= 1'b1;
    EXEC_VALID <= 1'b0;
    repeat (2) @(posedge MCLK);
    #1;
    chk1(TRACE_WE, 1'b0);
    chkp(PTR_VALUE, PTR_ZERO);
    // Disabled qualifier records nothing; a mid-run reset restores free-run
    exec(15'h0002, 1'b1, 1'b1);
    host(mk(OP_SET_QUALIFIER, 1'b0, 1'b0, 1'b0, ADDR_ZERO, ADDR_ZERO, QUAL_DISABLED), 0);
    exec(15'h0002, 1'b1, 1'b0);
    @(posedge MCLK);
    RST <= 1'b1;
    @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    #1;
    chk1(QUAL_MODE === QUAL_FREE_RUN, 1'b1);
    chkp(PTR_VALUE, PTR_ZERO);
    chk1(PTR_OVF, 1'b0);
    stop_test();
  end
endmodule // tfp_trace_filter_test
